/* rtl/uhcrm_regs.svh */
// Command codes, slot count and reset values of the host controller register map
`ifndef UHCRM_REGS_SVH
`define UHCRM_REGS_SVH

`define UHCRM_WR_BIT          7
`define UHCRM_CMD_REVISION    8'h00
`define UHCRM_CMD_OP_CTRL     8'h01
`define UHCRM_CMD_CMD_STATE   8'h02
`define UHCRM_CMD_EVT_FLAGS   8'h03
`define UHCRM_CMD_EVT_ENSET   8'h04
`define UHCRM_CMD_EVT_ENCLR   8'h05
`define UHCRM_CMD_FRM_IVAL    8'h0D
`define UHCRM_CMD_FRM_LEFT    8'h0E
`define UHCRM_CMD_FRM_INDEX   8'h0F
`define UHCRM_CMD_LS_LIMIT    8'h11
`define UHCRM_CMD_RH_DESC_A   8'h12
`define UHCRM_CMD_RH_DESC_B   8'h13
`define UHCRM_CMD_RH_STATE    8'h14
`define UHCRM_CMD_PORT1       8'h15
`define UHCRM_CMD_PORT2       8'h16
`define UHCRM_CMD_P_DONE      8'h17
`define UHCRM_CMD_P_SKIP      8'h18
`define UHCRM_CMD_P_LAST      8'h19
`define UHCRM_CMD_P_ACTIVE    8'h1A
`define UHCRM_CMD_A_DONE      8'h1B
`define UHCRM_CMD_A_SKIP      8'h1C
`define UHCRM_CMD_A_LAST      8'h1D
`define UHCRM_CMD_A_ACTIVE    8'h1E
`define UHCRM_CMD_HW_CFG      8'h20
`define UHCRM_CMD_DMA_CFG     8'h21
`define UHCRM_CMD_XFER_CNT    8'h22
`define UHCRM_CMD_IRQ_FLAGS   8'h24
`define UHCRM_CMD_IRQ_EN      8'h25
`define UHCRM_CMD_CHIP_ID     8'h27
`define UHCRM_CMD_SCRATCH     8'h28
`define UHCRM_CMD_SOFT_RST    8'hA9
`define UHCRM_CMD_BUF_STATE   8'h2C
`define UHCRM_CMD_ISO_SIZE    8'h30
`define UHCRM_CMD_DIRECT_WIN  8'h32
`define UHCRM_CMD_P_BUF_SIZE  8'h33
`define UHCRM_CMD_A_BUF_SIZE  8'h34
`define UHCRM_CMD_ISO0_PORT   8'h40
`define UHCRM_CMD_ISO1_PORT   8'h42
`define UHCRM_CMD_P_BUF_PORT  8'h43
`define UHCRM_CMD_A_BUF_PORT  8'h44
`define UHCRM_CMD_DIRECT_DATA 8'h45
`define UHCRM_CMD_ISO_TOGGLE  8'h47
`define UHCRM_CMD_A_DONE_CNT  8'h51
`define UHCRM_CMD_A_DONE_TMO  8'h52
`define UHCRM_CMD_P_BLK_SIZE  8'h53
`define UHCRM_CMD_A_BLK_SIZE  8'h54

`define UHCRM_SLOTS           128
`define UHCRM_RESET_WORD      32'h0000_0000
`define UHCRM_REVISION_VALUE  32'h0000_0011
`define UHCRM_RST_KEY         16'h00F6
`endif

/* rtl/uhcrm_pkg.sv */
// Types shared by the host controller register map
package uhcrm_pkg;
  typedef enum logic [1:0] {
    UHCRM_KIND_NONE = 2'b00,
    UHCRM_KIND_W16  = 2'b01,
    UHCRM_KIND_W32  = 2'b10
  } uhcrm_kind_t;

  typedef enum logic [1:0] {
    UHCRM_DIR_NONE = 2'b00,
    UHCRM_DIR_RO   = 2'b01,
    UHCRM_DIR_RW   = 2'b10,
    UHCRM_DIR_WO   = 2'b11
  } uhcrm_dir_t;

  typedef enum logic [1:0] {
    UHCRM_ST_IDLE   = 2'b00,
    UHCRM_ST_ACCESS = 2'b01
  } uhcrm_state_t;
endpackage

/* rtl/usb_host_cmd_register_map.sv */
// APB slave holding the command-coded register map of the USB host controller
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "uhcrm_regs.svh"
// What this block does
// (R1) Control, frame and root hub groups are 32-bit operational registers.
// (R2) Driver must not assume reserved fields read back as zero.
// (R3) Driver keeps reserved bits unchanged by read-modify-write or shadow copy.
// (R4) Driver writes reserved bit positions as zero when setting or clearing.
// (R5) Operational register command equals classic byte offset divided by four.
// (R6) Revision reads at 00 only; control group reads 01-05, writes 81-85.
// (R7) Frame group reads 0D-0F, writes 8D-8F; low-speed limit 11/91.
// (R8) Root hub reads 12-16, writes 92-96, two port registers included.
// (R9) Five 16-bit config/interrupt registers at 20,21,22,24,25 / A0-A5.
// (R10) Read-only identity at 27; 16-bit scratch at 28/A8.
// (R11) Soft reset register is write-only at A9, no read code.
// (R12) Buffer state 2C/AC, direct window 32/B2, direct data 45/C5.
// (R13) Iso size 30/B0, ports 40/C0, 42/C2, toggle rate 47/C7.
// (R14) Periodic and aperiodic done bitmaps read-only at 17 and 1B.
// (R15) Periodic list: sizes, port, skip, last, read-only active entry at 1A.
// (R16) Aperiodic list: sizes, port, skip, last, read-only active entry at 1E.
// (R17) Aperiodic done count limit 51/D1 and timeout limit 52/D2.
// (R18) Write code is read code with bit 7 set; unknown codes refused with pslverr.
// (R19) 16-bit registers take low half on write, read zero upper half.
module usb_host_cmd_register_map
  import uhcrm_pkg::*;
#(
  parameter logic [15:0] CHIP_ID_VALUE = 16'h5A00  // Arbitrary neutral value
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] periodicDoneIn,
  input  wire logic [31:0] asyncDoneIn,
  input  wire logic [15:0] periodicActiveIn,
  input  wire logic [15:0] asyncActiveIn,
  output logic      [31:0] opControl,
  output logic      [15:0] hwConfig,
  output logic             softResetPulse
);

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Byte address is four times the command code; bit 7 of the code selects write
  logic [7:0]  cmdCode;
  logic [6:0]  slot;
  logic        cmdWrite;
  uhcrm_kind_t slotKind;
  uhcrm_dir_t  slotDir;

  assign cmdCode  = paddr[9:2];
  assign slot     = cmdCode[6:0];
  assign cmdWrite = cmdCode[`UHCRM_WR_BIT];  // [R18]

  always_comb begin
    slotKind = UHCRM_KIND_NONE;
    slotDir  = UHCRM_DIR_NONE;
    case ({1'b0, slot})
      `UHCRM_CMD_REVISION: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RO;  // [R6]
      end
      `UHCRM_CMD_OP_CTRL, `UHCRM_CMD_CMD_STATE, `UHCRM_CMD_EVT_FLAGS: begin
        slotKind = UHCRM_KIND_W32;  // [R1] [R5]
        slotDir  = UHCRM_DIR_RW;    // [R6]
      end
      `UHCRM_CMD_EVT_ENSET, `UHCRM_CMD_EVT_ENCLR: begin
        slotKind = UHCRM_KIND_W32;  // [R1] [R5]
        slotDir  = UHCRM_DIR_RW;    // [R6]
      end
      `UHCRM_CMD_FRM_IVAL, `UHCRM_CMD_FRM_LEFT, `UHCRM_CMD_FRM_INDEX: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RW;  // [R7]
      end
      `UHCRM_CMD_LS_LIMIT: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RW;  // [R7]
      end
      `UHCRM_CMD_RH_DESC_A, `UHCRM_CMD_RH_DESC_B, `UHCRM_CMD_RH_STATE: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RW;  // [R8]
      end
      `UHCRM_CMD_PORT1, `UHCRM_CMD_PORT2: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RW;  // [R8]
      end
      `UHCRM_CMD_HW_CFG, `UHCRM_CMD_DMA_CFG, `UHCRM_CMD_XFER_CNT: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R9]
      end
      `UHCRM_CMD_IRQ_FLAGS, `UHCRM_CMD_IRQ_EN: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R9]
      end
      `UHCRM_CMD_CHIP_ID: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RO;  // [R10]
      end
      `UHCRM_CMD_SCRATCH: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R10]
      end
      (`UHCRM_CMD_SOFT_RST & 8'h7F): begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_WO;  // [R11]
      end
      `UHCRM_CMD_BUF_STATE: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R12]
      end
      `UHCRM_CMD_DIRECT_DATA: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R12]
      end
      `UHCRM_CMD_DIRECT_WIN: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RW;  // [R12]
      end
      `UHCRM_CMD_ISO_SIZE, `UHCRM_CMD_ISO_TOGGLE: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R13]
      end
      `UHCRM_CMD_ISO0_PORT, `UHCRM_CMD_ISO1_PORT: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R13]
      end
      `UHCRM_CMD_P_DONE: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RO;  // [R14]
      end
      `UHCRM_CMD_A_DONE: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RO;  // [R14]
      end
      `UHCRM_CMD_P_BUF_SIZE, `UHCRM_CMD_P_BLK_SIZE: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R15]
      end
      `UHCRM_CMD_P_BUF_PORT: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R15]
      end
      `UHCRM_CMD_P_SKIP, `UHCRM_CMD_P_LAST: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RW;  // [R15]
      end
      `UHCRM_CMD_P_ACTIVE: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RO;  // [R15]
      end
      `UHCRM_CMD_A_BUF_SIZE, `UHCRM_CMD_A_BLK_SIZE: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R16]
      end
      `UHCRM_CMD_A_BUF_PORT: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R16]
      end
      `UHCRM_CMD_A_SKIP, `UHCRM_CMD_A_LAST: begin
        slotKind = UHCRM_KIND_W32;
        slotDir  = UHCRM_DIR_RW;  // [R16]
      end
      `UHCRM_CMD_A_ACTIVE: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RO;  // [R16]
      end
      `UHCRM_CMD_A_DONE_CNT: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R17]
      end
      `UHCRM_CMD_A_DONE_TMO: begin
        slotKind = UHCRM_KIND_W16;
        slotDir  = UHCRM_DIR_RW;  // [R17]
      end
      default: begin
        slotKind = UHCRM_KIND_NONE;
        slotDir  = UHCRM_DIR_NONE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Access legality
  // ----------------------------------------------------------------------
  logic cmdOk;
  logic readOk;
  logic writeOk;
  logic addrOk;
  logic accessPhase;
  logic dirReadable;
  logic dirWritable;
  logic writeCommit;
  logic keyMatch;

  // Direction table: which transfer directions each kind of slot takes
  always_comb begin
    dirReadable = 1'b0;
    dirWritable = 1'b0;
    case (slotDir)
      UHCRM_DIR_RO: begin
        dirReadable = 1'b1;
      end
      UHCRM_DIR_RW: begin
        dirReadable = 1'b1;
        dirWritable = 1'b1;
      end
      UHCRM_DIR_WO: begin
        dirWritable = 1'b1;
      end
      default: begin
        dirReadable = 1'b0;
        dirWritable = 1'b0;
      end
    endcase
  end

  // The APB direction must agree with bit 7 of the command code
  assign addrOk  = (paddr[31:10] == 22'h00_0000) && (paddr[1:0] == 2'b00);
  assign readOk  = !pwrite && !cmdWrite && dirReadable;  // [R18]
  assign writeOk = pwrite && cmdWrite && dirWritable;    // [R18]
  assign cmdOk   = addrOk && (readOk || writeOk);
  assign accessPhase = psel && penable && !pready;

  // A write takes effect at the edge that ends the first access cycle
  assign writeCommit = accessPhase && cmdOk && pwrite;
  assign keyMatch    = (pwdata[15:0] == `UHCRM_RST_KEY);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [31:0] regFile [0:`UHCRM_SLOTS-1];
  logic [31:0] mergedWord;
  logic [31:0] storeWord;

  always_comb begin
    mergedWord = regFile[slot];
    for (int b = 0; b < 4; b++) begin
      if (pstrb[b]) begin
        mergedWord[b*8 +: 8] = pwdata[b*8 +: 8];
      end
    end
    storeWord = (slotKind == UHCRM_KIND_W16) ? {16'h0000, mergedWord[15:0]}
                                             : mergedWord;  // [R19]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `UHCRM_SLOTS; i++) begin
        regFile[i] <= `UHCRM_RESET_WORD;
      end
    end else if (writeCommit && slotDir == UHCRM_DIR_RW) begin
      regFile[slot] <= storeWord;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  logic [31:0] readWord;
  logic [31:0] readMasked;

  always_comb begin
    case ({1'b0, slot})
      `UHCRM_CMD_REVISION: readWord = `UHCRM_REVISION_VALUE;           // [R6]
      `UHCRM_CMD_CHIP_ID:  readWord = {16'h0000, CHIP_ID_VALUE};       // [R10]
      `UHCRM_CMD_P_DONE:   readWord = periodicDoneIn;                  // [R14]
      `UHCRM_CMD_A_DONE:   readWord = asyncDoneIn;                     // [R14]
      `UHCRM_CMD_P_ACTIVE: readWord = {16'h0000, periodicActiveIn};    // [R15]
      `UHCRM_CMD_A_ACTIVE: readWord = {16'h0000, asyncActiveIn};       // [R16]
      default:             readWord = regFile[slot];                   // [R19]
    endcase
  end

  // Half-width slots never show stale upper bits
  always_comb begin
    readMasked = readWord;
    if (slotKind == UHCRM_KIND_W16) begin
      readMasked = {16'h0000, readWord[15:0]};  // [R19]
    end
  end

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= accessPhase;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (accessPhase) begin
      prdata <= (cmdOk && !pwrite) ? readMasked : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else if (accessPhase) begin
      pslverr <= !cmdOk;  // [R18]
    end else begin
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Side effects
  // ----------------------------------------------------------------------
  // Soft reset fires only when the key value is written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      softResetPulse <= 1'b0;
    end else begin
      softResetPulse <= writeCommit && slotDir == UHCRM_DIR_WO && keyMatch;  // [R11]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opControl <= 32'h0000_0000;
    end else begin
      opControl <= regFile[7'(`UHCRM_CMD_OP_CTRL)];  // [R6]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hwConfig <= 16'h0000;
    end else begin
      hwConfig <= regFile[7'(`UHCRM_CMD_HW_CFG)][15:0];  // [R9]
    end
  end

endmodule

/* verification/uhcrm_checker_assertions.sv */
// Concurrent checks on the register map's bus answers and copies
`timescale 1ns/1ps
module uhcrm_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] opControl,
  input wire logic [15:0] hwConfig,
  input wire logic        softResetPulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Access phases
  // ----------------------------------------
  sequence s_wait;
    psel && penable && !pready;
  endsequence

  sequence s_done(logic [31:0] a, logic w);
    pready && psel && penable && pwrite == w && paddr == a;
  endsequence

  a_one_wait: assert property (s_wait |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_blank: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("refused access carried data");
  a_rev_read: assert property (s_done(32'h0000_0000, 1'b0)
    |-> !pslverr && prdata == 32'h0000_0011)
    else $error("revision read wrong");
  a_rev_nowrite: assert property (s_done(32'h0000_0200, 1'b1) |-> pslverr)
    else $error("revision write accepted");
  a_chipid_nowrite: assert property (s_done(32'h0000_029C, 1'b1) |-> pslverr)
    else $error("identity write accepted");
  a_reset_noread: assert property (s_done(32'h0000_02A4, 1'b0) |-> pslverr)
    else $error("soft reset read accepted");
  a_done_nowrite: assert property (s_done(32'h0000_025C, 1'b1) |-> pslverr)
    else $error("done bitmap write accepted");
  a_half_upper: assert property (s_done(32'h0000_0080, 1'b0)
    |-> prdata[31:16] == 16'h0000)
    else $error("upper half of 16-bit read not zero");
  a_ctl_copy: assert property (s_done(32'h0000_0204, 1'b1) ##0 !pslverr
    |=> ##1 opControl == $past(pwdata, 2))
    else $error("control copy not updated");
  a_hwcfg_copy: assert property (s_done(32'h0000_0280, 1'b1) ##0 !pslverr
    |=> ##1 hwConfig == $past(pwdata[15:0], 2))
    else $error("config copy not updated");
  a_rst_pulse: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset pulse too long");
endmodule

/* verification/uhcrm_status_model.sv */
// Live list status source standing in for the transfer engine
`timescale 1ns/1ps
module uhcrm_status_model (
  input  wire logic        flip,
  output logic      [31:0] periodicDone,
  output logic      [31:0] asyncDone,
  output logic      [15:0] periodicActive,
  output logic      [15:0] asyncActive
);
  // Distinct patterns per list so a swapped decode shows
  assign periodicDone   = flip ? 32'h0F0F_A5A5 : 32'h1234_8001;
  assign asyncDone      = flip ? 32'hC001_7E57 : 32'h8000_4321;
  assign periodicActive = flip ? 16'h00A1 : 16'h0013;
  assign asyncActive    = flip ? 16'h00B2 : 16'h0024;
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the host controller register map
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] CHIP_ID = 16'h3C96;  // Arbitrary test value
  localparam logic [8:0] REGS [39] = '{9'h101, 9'h102, 9'h103, 9'h104, 9'h105, 9'h10D, 9'h10E,
    9'h10F, 9'h111, 9'h112, 9'h113, 9'h114, 9'h115, 9'h116, 9'h118, 9'h119, 9'h11C, 9'h11D,
    9'h132, 9'h020, 9'h021, 9'h022, 9'h024, 9'h025, 9'h028, 9'h02C, 9'h030, 9'h033, 9'h034,
    9'h040, 9'h042, 9'h043, 9'h044, 9'h045, 9'h047, 9'h051, 9'h052, 9'h053, 9'h054};
  localparam logic [8:0] BAD [13] = '{9'h006, 9'h029, 9'h0A9, 9'h081, 9'h07F, 9'h180, 9'h1A7,
    9'h197, 9'h19A, 9'h19B, 9'h19E, 9'h186, 9'h101};
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, softResetPulse, flip, rdErr;
  logic [31:0] paddr, pwdata, prdata, opControl, periodicDone, asyncDone, rdVal, pat;
  logic [15:0] hwConfig, periodicActive, asyncActive;
  int          miscompares, cmp_count, pulseCount;

  usb_host_cmd_register_map #(.CHIP_ID_VALUE(CHIP_ID)) i_usb_host_cmd_register_map (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periodicDoneIn(periodicDone), .asyncDoneIn(asyncDone), .periodicActiveIn(periodicActive),
    .asyncActiveIn(asyncActive), .opControl(opControl), .hwConfig(hwConfig),
    .softResetPulse(softResetPulse));
  uhcrm_status_model i_uhcrm_status_model (.flip(flip), .periodicDone(periodicDone),
    .asyncDone(asyncDone), .periodicActive(periodicActive), .asyncActive(asyncActive));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (softResetPulse === 1'b1) pulseCount <= pulseCount + 1;

  // ----------------------------------------
  // Bus, check and finish tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] code, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {22'h0, code, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdVal = prdata;
    rdErr = pslverr;
    if (n >= 16) chk("pready", 32'h1, 32'h0);
    penable <= 1'b0;
    psel    <= 1'b0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    {psel, penable, pwrite, flip} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("revision", 32'h0000_0011, rdVal);
    chk("rev field", 32'h0000_0011, rdVal & 32'h0000_00FF);
    apb(1'b0, 8'h27, 32'h0);
    chk("chip id", {16'h0000, CHIP_ID}, rdVal);
    foreach (REGS[i]) begin
      pat = {REGS[i][7:0], 8'h5A, ~REGS[i][7:0], 8'hC3};
      apb(1'b0, REGS[i][7:0], 32'h0);
      chk("reset", 32'h0, rdVal);
      apb(1'b1, REGS[i][7:0] | 8'h80, pat);
      chk("wr err", 32'h0, {31'h0, rdErr});
      apb(1'b0, REGS[i][7:0], 32'h0);
      chk("rw", REGS[i][8] ? pat : {16'h0, pat[15:0]}, rdVal);
    end
    chk("opControl", 32'h015A_FEC3, opControl);
    chk("hwConfig", 32'h0000_DFC3, {16'h0, hwConfig});
    foreach (BAD[i]) begin
      apb(BAD[i][8], BAD[i][7:0], 32'hFFFF_FFFF);
      chk("refused", 32'h1, {31'h0, rdErr});
    end
    apb(1'b0, 8'h01, 32'h0);
    chk("control kept", 32'h015A_FEC3, rdVal);
    repeat (2) begin
      apb(1'b0, 8'h17, 32'h0);
      chk("periodic done", periodicDone, rdVal);
      apb(1'b0, 8'h1B, 32'h0);
      chk("async done", asyncDone, rdVal);
      apb(1'b0, 8'h1A, 32'h0);
      chk("periodic active", {16'h0, periodicActive}, rdVal);
      apb(1'b0, 8'h1E, 32'h0);
      chk("async active", {16'h0, asyncActive}, rdVal);
      flip <= ~flip;
    end
    apb(1'b1, 8'hA9, 32'h0000_0F6F);
    apb(1'b1, 8'hA9, 32'h0000_00F6);
    repeat (3) @(posedge clk);
    chk("reset pulses", 32'h1, pulseCount);
    apb(1'b0, 8'h28, 32'h0);
    chk("scratch kept", 32'h0000_D7C3, rdVal);
    apb(1'b1, 8'hA8, {16'h0000, rdVal[15:0] ^ 16'h00FF});
    apb(1'b0, 8'h28, 32'h0);
    chk("scratch rmw", 32'h0000_D73C, rdVal);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h28, 32'h0);
    chk("scratch reset", 32'h0, rdVal);
    finish_test();
  end
endmodule

bind usb_host_cmd_register_map uhcrm_checker i_uhcrm_checker (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .opControl(opControl),
  .hwConfig(hwConfig), .softResetPulse(softResetPulse));
